/* File: uart_status_pkg.sv */
`default_nettype none

package uart_status_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] ADDR_STATUS = 5'h00; // Status and control word.
  localparam logic [4:0] ADDR_RXDATA = 5'h04; // Read pops one character.
  localparam logic [4:0] ADDR_TXDATA = 5'h08; // Write queues one character.
  localparam logic [4:0] ADDR_MODE = 5'h0c; // Character format.
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10; // Sticky events, W1C.
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14; // Interrupt enables.

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the status and control word.
  localparam int BIT_TX_DRAINED = 8;
  localparam int SEL_LSB = 6;
  localparam int BIT_ADDR_EN = 5;
  localparam int BIT_RX_IDLE = 4;
  localparam int BIT_PARITY = 3;
  localparam int BIT_FRAMING = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_AVAIL = 0;

  // Receive interrupt threshold encodings; the fourth code is reserved.
  localparam logic [1:0] SEL_ANY = 2'h0;
  localparam logic [1:0] SEL_HALF = 2'h1;
  localparam logic [1:0] SEL_THREEQ = 2'h2;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // Receive buffer depth and occupancy thresholds.
  localparam int RX_DEPTH = 8;
  localparam int LVL_W = 4;
  localparam logic [LVL_W-1:0] THRESH_ANY = 4'h1;
  localparam logic [LVL_W-1:0] THRESH_HALF = 4'h4;
  localparam logic [LVL_W-1:0] THRESH_THREEQ = 4'h6;

  // Character format bits in the mode word.
  localparam int MODE_NINE = 0;
  localparam int MODE_PAR_EN = 1;
  localparam int MODE_PAR_ODD = 2;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // Sticky interrupt event bits.
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_RX_ERR = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // Clock cycles per serial bit at the core clock rate.
  localparam int DEFAULT_BIT_CYCLES = 16;

  // One received character with its error marks.
  typedef struct packed {
    logic framing;
    logic parity;
    logic [8:0] data;
  } rx_char_s;

endpackage : uart_status_pkg

`default_nettype wire

/* File: uart_rx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_rx_fifo #(
  parameter int DEPTH = uart_status_pkg::RX_DEPTH,
  parameter int CNT_W = uart_status_pkg::LVL_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic pushValid,
  input wire uart_status_pkg::rx_char_s pushData,
  output logic pushReady,
  input wire logic popReady,
  output uart_status_pkg::rx_char_s headData,
  output logic headValid,
  output logic [CNT_W-1:0] level
);
  import uart_status_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  rx_char_s mem [DEPTH]; // Character storage.
  logic [PTR_W-1:0] wrPtr_q; // Next slot to fill.
  logic [PTR_W-1:0] rdPtr_q; // Oldest character.
  logic [CNT_W-1:0] count_q; // Characters held.

  // A push into a full buffer is refused; the caller treats it as overrun.
  wire doPush = pushValid && pushReady;
  wire doPop = popReady && headValid;

  assign pushReady = (count_q != CNT_W'(DEPTH));
  assign headValid = (count_q != '0);
  assign headData = mem[rdPtr_q];
  assign level = count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Storage has no reset; only the pointers and the count need a defined value.
  always_ff @(posedge core_clk)
  begin
    if (doPush && !flush)
    begin
      mem[wrPtr_q] <= pushData;
    end
  end

  // Pointers wrap because the depth is a power of two.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_q + PTR_W'(doPush);
      rdPtr_q <= rdPtr_q + PTR_W'(doPop);
      count_q <= count_q + CNT_W'(doPush) - CNT_W'(doPop);
    end
  end

endmodule : uart_rx_fifo

`default_nettype wire

/* File: uart_status_flags.sv */
// Operation
// - Drained flag high only when shifter and buffer empty.
// - Selection 10 flags six or more characters.
// - Selection 01 flags four or more characters.
// - Selection 00 flags any stored character.
// - Nine-bit address mode keeps only address characters.
// - Idle flag high unless a character arrives.
// - Parity flag marks the current character.
// - Framing flag marks the current character.
// - Overrun set by hardware, cleared only by software.
// - Clearing overrun empties buffer and shift register.
// - Data available high while buffer is not empty.
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uart_status_flags #(
  parameter int BIT_CYCLES = uart_status_pkg::DEFAULT_BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic rx_irq_flag,
  input wire logic serial_rx,
  output logic serial_tx
);
  import uart_status_pkg::*;

  localparam int CNT_W = $clog2(BIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] FULL_BIT = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYCLES / 2 - 1);

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_FLUSHED} rx_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the request is taken.
  logic ack_q; // High in the cycle the request is accepted.
  logic [31:0] readData_q; // Read word, captured during the wait cycle.
  wire req = avs_read || avs_write;
  wire accept = req && ack_q;
  wire wrAcc = accept && avs_write;
  wire rdAcc = accept && avs_read;
  wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wrBits = avs_writedata & beMask;

  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata = readData_q;

  // Register selects.
  wire selStatus = (avs_address == ADDR_STATUS);
  wire selRxData = (avs_address == ADDR_RXDATA);
  wire selTxData = (avs_address == ADDR_TXDATA);
  wire selMode = (avs_address == ADDR_MODE);
  wire selIrqSt = (avs_address == ADDR_IRQ_STATUS);
  wire selIrqMask = (avs_address == ADDR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Software state.
  logic [1:0] thrSel_q; // rx_irq_threshold_sel.
  logic addrEn_q; // addr_char_detect_en.
  logic overrun_q; // rx_overrun.
  logic [2:0] mode_q; // Nine-bit, parity enable, odd parity.
  logic [IRQ_W-1:0] irqSt_q; // Sticky events.
  logic [IRQ_W-1:0] irqMask_q; // Event enables.

  wire nineBit = mode_q[MODE_NINE];
  wire parEn = mode_q[MODE_PAR_EN] && !nineBit;
  wire parOdd = mode_q[MODE_PAR_ODD];

  // Status write fields, honouring byte lanes.
  wire stWr = wrAcc && selStatus;
  wire [31:0] stNew = (wrBits) | ({24'h0, thrSel_q, addrEn_q, 5'h0} & ~beMask);
  // Only a written zero over a set flag clears overrun.
  wire ovClr = stWr && avs_byteenable[0] && !avs_writedata[BIT_OVERRUN]
               && overrun_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and its head.
  rx_char_s pushChar;
  rx_char_s headChar;
  logic rxPush;
  logic pushReady;
  logic headValid;
  logic [LVL_W-1:0] rxLevel;
  wire rxPop = rdAcc && selRxData;

  uart_rx_fifo #(
    .DEPTH(RX_DEPTH),
    .CNT_W(LVL_W)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(ovClr),
    .pushValid(rxPush),
    .pushData(pushChar),
    .pushReady(pushReady),
    .popReady(rxPop),
    .headData(headChar),
    .headValid(headValid),
    .level(rxLevel)
  );

  // Error flags reflect only the character that will be read next.
  wire rxAvail = headValid;
  wire parityErr = headValid && headChar.parity;
  wire framingErr = headValid && headChar.framing;
  wire overrunEv = rxPush && !pushReady;

  // Threshold select; the reserved code is never written by software.
  wire thrThreeQ = (rxLevel >= THRESH_THREEQ);
  wire thrHalf = (rxLevel >= THRESH_HALF);
  wire thrAny = (rxLevel >= THRESH_ANY);
  assign rx_irq_flag = (thrSel_q == SEL_THREEQ) ? thrThreeQ :
                       (thrSel_q == SEL_HALF) ? thrHalf : thrAny;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding buffer and shifter.
  tx_state_e txState_q;
  logic txBufValid_q; // Character queued behind the shifter.
  logic [8:0] txBuf_q;
  logic [10:0] txShift_q; // Frame, least significant bit first.
  logic [3:0] txBits_q; // Bits left in the frame.
  logic [CNT_W-1:0] txCnt_q; // Cycles left in the current bit.
  logic txLine_q;
  logic txDrainedPrev_q;

  // Drained only when nothing is shifting and nothing is queued.
  wire txDrained = (txState_q == TX_IDLE) && !txBufValid_q;
  // A write while the buffer is full is dropped.
  wire txPush = wrAcc && selTxData && avs_byteenable[0] && !txBufValid_q;
  wire txLoad = (txState_q == TX_IDLE) && txBufValid_q;
  wire txExt = nineBit ? txBuf_q[8] : (parEn ? (^txBuf_q[7:0] ^ parOdd)
                                             : 1'b1);
  wire [3:0] frameLen = (nineBit || parEn) ? 4'hb : 4'ha;
  wire txBitEnd = (txCnt_q == '0);

  // Buffer fills from the bus and empties into the shifter.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txBufValid_q <= 1'b0;
      txBuf_q <= '0;
    end
    else if (txPush)
    begin
      txBufValid_q <= 1'b1;
      txBuf_q <= avs_writedata[8:0];
    end
    else if (txLoad)
    begin
      txBufValid_q <= 1'b0;
    end
  end

  // Shifter: start bit, data, optional ninth or parity bit, stop bit.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState_q <= TX_IDLE;
      txShift_q <= '1;
      txBits_q <= '0;
      txCnt_q <= '0;
      txLine_q <= 1'b1;
    end
    else
    begin
      case (txState_q)
        TX_IDLE:
        begin
          txLine_q <= 1'b1;
          if (txLoad)
          begin
            txState_q <= TX_SHIFT;
            txShift_q <= {1'b1, txExt, txBuf_q[7:0], 1'b0};
            txBits_q <= frameLen;
            txCnt_q <= FULL_BIT;
            txLine_q <= 1'b0;
          end
        end
        TX_SHIFT:
        begin
          txCnt_q <= txBitEnd ? FULL_BIT : txCnt_q - 1'b1;
          if (txBitEnd)
          begin
            txShift_q <= {1'b1, txShift_q[10:1]};
            txBits_q <= txBits_q - 1'b1;
            txLine_q <= txShift_q[1];
            if (txBits_q == 4'h1)
            begin
              txState_q <= TX_IDLE;
              txLine_q <= 1'b1;
            end
          end
        end
        default:
        begin
          txState_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign serial_tx = txLine_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples mid-bit, start bit included in the shift register.
  rx_state_e rxState_q;
  logic [10:0] rxShift_q; // rx_shift_register, filled from the top.
  logic [3:0] rxBit_q; // Bits sampled so far.
  logic [CNT_W-1:0] rxCnt_q;

  wire rxSample = (rxState_q == RX_RECV) && (rxCnt_q == '0);
  wire [10:0] rxFull = {serial_rx, rxShift_q[10:1]};
  wire rxFalse = rxSample && (rxBit_q == 4'h0) && serial_rx;
  wire rxDone = rxSample && !rxFalse && (rxBit_q == frameLen - 4'h1);
  wire [7:0] rxData8 = (nineBit || parEn) ? rxFull[8:1] : rxFull[9:2];
  wire rxExt = rxFull[9];
  wire rxIdle = (rxState_q != RX_RECV);

  // Characters with a clear ninth bit are dropped in address mode.
  wire rxKeep = !(addrEn_q && nineBit && !rxExt);

  always_comb
  begin
    pushChar.data = {nineBit && rxExt, rxData8};
    pushChar.parity = parEn && ((^rxData8 ^ rxExt) != parOdd);
    pushChar.framing = !rxFull[10];
  end

  assign rxPush = rxDone && rxKeep && !ovClr;

  // Clearing overrun also discards any half-received character.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_q <= RX_IDLE;
      rxShift_q <= '0;
      rxBit_q <= '0;
      rxCnt_q <= '0;
    end
    else if (ovClr)
    begin
      rxState_q <= RX_FLUSHED;
      rxShift_q <= '0;
      rxBit_q <= '0;
    end
    else
    begin
      case (rxState_q)
        RX_IDLE, RX_FLUSHED:
        begin
          rxState_q <= RX_IDLE;
          if (!serial_rx)
          begin
            rxState_q <= RX_RECV;
            rxCnt_q <= HALF_BIT;
            rxBit_q <= '0;
          end
        end
        RX_RECV:
        begin
          rxCnt_q <= rxSample ? FULL_BIT : rxCnt_q - 1'b1;
          if (rxSample)
          begin
            rxShift_q <= rxFull;
            rxBit_q <= rxBit_q + 1'b1;
          end
          if (rxFalse || rxDone)
          begin
            rxState_q <= RX_IDLE;
          end
        end
        default:
        begin
          rxState_q <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; a clear blocks any push in the same cycle, so no fresh overrun can race it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thrSel_q <= SEL_RESET;
      addrEn_q <= 1'b0;
      overrun_q <= 1'b0;
      mode_q <= MODE_RESET;
    end
    else
    begin
      if (stWr)
      begin
        thrSel_q <= stNew[SEL_LSB +: 2];
        addrEn_q <= stNew[BIT_ADDR_EN];
      end
      if (overrunEv)
      begin
        overrun_q <= 1'b1;
      end
      else if (ovClr)
      begin
        overrun_q <= 1'b0;
      end
      if (wrAcc && selMode && avs_byteenable[0])
      begin
        mode_q <= avs_writedata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events, mask and the level output.
  wire [IRQ_W-1:0] irqSet = {rxPush && (pushChar.parity || pushChar.framing),
                             txDrained && !txDrainedPrev_q,
                             overrunEv, rx_irq_flag};
  wire [IRQ_W-1:0] irqClr = (wrAcc && selIrqSt) ? wrBits[IRQ_W-1:0] : '0;

  // Set wins over a write-one clear arriving in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqSt_q <= IRQ_RESET;
      irqMask_q <= IRQ_RESET;
      txDrainedPrev_q <= 1'b1;
    end
    else
    begin
      irqSt_q <= (irqSt_q & ~irqClr) | irqSet;
      txDrainedPrev_q <= txDrained;
      if (wrAcc && selIrqMask)
      begin
        irqMask_q <= (wrBits[IRQ_W-1:0]) |
                     (irqMask_q & ~beMask[IRQ_W-1:0]);
      end
    end
  end

  assign irq = |(irqSt_q & irqMask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the wait cycle; unmapped words read zero.
  wire [31:0] statusWord = {23'h0, txDrained, thrSel_q, addrEn_q, rxIdle,
                            parityErr, framingErr, overrun_q, rxAvail};
  wire [31:0] rdMux = selStatus ? statusWord :
                      selRxData ? {21'h0, headChar} :
                      selTxData ? {23'h0, txBuf_q} :
                      selMode ? {29'h0, mode_q} :
                      selIrqSt ? {28'h0, irqSt_q} :
                      selIrqMask ? {28'h0, irqMask_q} : 32'h0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      readData_q <= '0;
    end
    else
    begin
      ack_q <= req && !ack_q;
      if (avs_read && !ack_q)
      begin
        readData_q <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_tx_drained;
    @(posedge core_clk) disable iff (!rst_n)
    txPush |=> !statusWord[BIT_TX_DRAINED] [*2];
  endproperty
  a_tx_drained: assert property (p_tx_drained)
    else $error("drained flag high with a character queued");

  property p_thr_threeq;
    @(posedge core_clk) disable iff (!rst_n)
    (thrSel_q == 2'h2) |-> (rx_irq_flag == (rxLevel >= 4'h6));
  endproperty
  a_thr_threeq: assert property (p_thr_threeq)
    else $error("three-quarter threshold flag wrong");

  property p_thr_half;
    @(posedge core_clk) disable iff (!rst_n)
    (thrSel_q == 2'h1) |-> (rx_irq_flag == (rxLevel >= 4'h4));
  endproperty
  a_thr_half: assert property (p_thr_half)
    else $error("half threshold flag wrong");

  property p_thr_any;
    @(posedge core_clk) disable iff (!rst_n)
    (thrSel_q == 2'h0) |-> (rx_irq_flag == rxAvail);
  endproperty
  a_thr_any: assert property (p_thr_any)
    else $error("not-empty threshold flag wrong");

  property p_addr_drop;
    @(posedge core_clk) disable iff (!rst_n)
    (rxDone && addrEn_q && nineBit && !rxExt && !rxPop) |=> $stable(rxLevel);
  endproperty
  a_addr_drop: assert property (p_addr_drop)
    else $error("data character stored in address mode");

  property p_rx_busy;
    @(posedge core_clk) disable iff (!rst_n)
    (rxState_q == RX_IDLE && !serial_rx && !ovClr) |=> !statusWord[BIT_RX_IDLE];
  endproperty
  a_rx_busy: assert property (p_rx_busy)
    else $error("idle flag high after start bit");

  property p_err_empty;
    @(posedge core_clk) disable iff (!rst_n)
    !statusWord[BIT_RX_AVAIL] |-> !statusWord[BIT_PARITY] &&
                                  !statusWord[BIT_FRAMING];
  endproperty
  a_err_empty: assert property (p_err_empty)
    else $error("error flag shown with empty buffer");

  property p_ovr_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (overrun_q && !ovClr) |=> overrun_q;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("overrun cleared without software");

  property p_ovr_set;
    @(posedge core_clk) disable iff (!rst_n)
    (rxPush && rxLevel == 4'h8) |=> overrun_q;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overflow did not set overrun");

  property p_ovr_flush;
    @(posedge core_clk) disable iff (!rst_n)
    ovClr && !overrunEv |=> (rxLevel == 4'h0) && rxIdle && !overrun_q;
  endproperty
  a_ovr_flush: assert property (p_ovr_flush)
    else $error("overrun clear did not empty receiver");

  property p_avail_pop;
    @(posedge core_clk) disable iff (!rst_n)
    (rxPop && rxLevel == 4'h1 && !rxPush) |=> !statusWord[BIT_RX_AVAIL];
  endproperty
  a_avail_pop: assert property (p_avail_pop)
    else $error("data available after last character read");

  c_rx_char: cover property (@(posedge core_clk) disable iff (!rst_n)
    rxPush);
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_n)
    overrunEv);
  c_tx_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(txDrained));

endmodule : uart_status_flags

`default_nettype wire

/* File: remote_serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-end transmitter and receiver on the two serial lines.
module remote_serial_peer #(
  parameter int BC = 4
) (
  input wire logic core_clk,
  input wire logic serial_tx,
  output var logic serial_rx
);
  // The line idles high between frames.
  initial serial_rx = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // One frame: start, nb bits LSB first, stop level stp, two idle bit times.
  task automatic send_char(input logic [8:0] d, input int nb, input logic stp);
    @(posedge core_clk);
    serial_rx <= 1'b0;
    repeat (BC) @(posedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      serial_rx <= d[i];
      repeat (BC) @(posedge core_clk);
    end
    serial_rx <= stp;
    repeat (BC) @(posedge core_clk);
    serial_rx <= 1'b1;
    repeat (BC * 2) @(posedge core_clk);
  endtask : send_char

  // Waits for a start bit, then samples nb bits near their middles.
  task automatic recv_char(input int nb, output logic [8:0] d);
    d = '0;
    do @(posedge core_clk); while (serial_tx !== 1'b0);
    repeat (BC / 2) @(posedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (BC) @(posedge core_clk);
      d[i] = serial_tx;
    end
  endtask : recv_char
endmodule : remote_serial_peer

`default_nettype wire

/* File: test_uart_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module test_uart_status_flags;
  import uart_status_pkg::*;
  localparam int BC = 4; // Short bit time keeps the run brief.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, rx_irq_flag, serial_rx, serial_tx;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] rnd = 32'd20;
  logic [10:0] mq[$]; // Model of the receive buffer.
  logic [1:0] sel = 2'h0;
  logic ovr = 1'b0;
  logic aen = 1'b0;
  logic nine = 1'b0;
  logic [31:0] q;
  logic [8:0] txw, rxd;

  always #12.5 core_clk = ~core_clk;

  uart_status_flags #(.BIT_CYCLES(BC)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .rx_irq_flag(rx_irq_flag), .serial_rx(serial_rx),
    .serial_tx(serial_tx));
  remote_serial_peer #(.BC(BC)) peer (.core_clk(core_clk),
    .serial_tx(serial_tx), .serial_rx(serial_rx));

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs

  // Status word as the model sees it; error bits follow the head entry.
  function logic [31:0] exp_stat();
    logic [1:0] err;
    err = (mq.size() != 0) ? {mq[0][9], mq[0][10]} : 2'b00;
    return {23'h0, 1'b1, sel, aen, 1'b1, err, ovr, mq.size() != 0};
  endfunction : exp_stat

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask : chk

  // One Avalon access, held until waitrequest is seen low at an edge.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // Send a frame and update the model; full buffer drops and flags.
  task rx(input logic [8:0] d, input int nb, input logic stp,
          input logic pe);
    int thr;
    peer.send_char(d, nb, stp);
    if (!(aen && nine && !d[8]))
    begin
      if (mq.size() == RX_DEPTH)
        ovr = 1'b1;
      else
        mq.push_back({!stp, pe, nine ? d : {1'b0, d[7:0]}});
    end
    thr = (sel == 2'h2) ? 6 : (sel == 2'h1) ? 4 : 1;
    chk(rx_irq_flag, mq.size() >= thr);
  endtask : rx

  task drain();
    while (mq.size() != 0)
    begin
      bus(1'b0, ADDR_RXDATA, 32'h0);
      chk(q, {21'h0, mq.pop_front()});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q, exp_stat());
    end
  endtask : drain

  task wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: far beyond the expected few thousand cycles.
  initial
  begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h110);
    // Every legal threshold code; the reserved one is never written.
    for (int s = 0; s < 3; s++)
    begin
      sel = s[1:0];
      bus(1'b1, ADDR_STATUS, {24'h0, sel, 6'h0});
      for (int i = 0; i < 7; i++)
        rx({1'b0, 8'(xs())}, 8, 1'b1, 1'b0);
      drain();
    end
    sel = 2'h0;
    bus(1'b1, ADDR_STATUS, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h2);
    for (int i = 0; i < 9; i++)
      rx({1'b0, 8'(xs())}, 8, 1'b1, 1'b0);
    bus(1'b1, ADDR_STATUS, 32'h2);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, exp_stat());
    chk(irq, 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h0);
    mq.delete();
    ovr = 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, exp_stat());
    bus(1'b1, ADDR_IRQ_STATUS, 32'h2);
    @(posedge core_clk);
    chk(irq, 1'b0);
    // Idle flag drops while a frame is on the line.
    fork
      rx({1'b0, 8'(xs())}, 8, 1'b1, 1'b0);
      begin
        repeat (BC * 3) @(posedge core_clk);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q[BIT_RX_IDLE], 1'b0);
      end
    join
    rx({1'b0, 8'(xs())}, 8, 1'b0, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, exp_stat());
    drain();
    bus(1'b1, ADDR_MODE, 32'h2);
    q = xs();
    rx({~^q[7:0], q[7:0]}, 9, 1'b1, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, exp_stat());
    drain();
    bus(1'b1, ADDR_MODE, 32'h1);
    nine = 1'b1;
    aen = 1'b1;
    bus(1'b1, ADDR_STATUS, 32'h20);
    rx(9'h0a5, 9, 1'b1, 1'b0);
    rx(9'h15a, 9, 1'b1, 1'b0);
    drain();
    // The far end decodes the nine-bit frame that the shifter sends.
    txw = 9'(xs());
    fork
      peer.recv_char(9, rxd);
      begin
        bus(1'b1, ADDR_TXDATA, {23'h0, txw});
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q[BIT_TX_DRAINED], 1'b0);
      end
    join
    chk(rxd, txw);
    repeat (BC * 14) @(posedge core_clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q[BIT_TX_DRAINED], 1'b1);
    wrap_up();
  end
endmodule : test_uart_status_flags

`default_nettype wire
